// ==== tb/ialsa_issue_model.sv ====
// decoder-side model that issues operations to the datapath
`timescale 1ns/1ns
module ialsa_issue_model (
  // clock
  input wire logic core_clk,
  // issue toward the datapath
  output logic opValid,
  output ialsa_pkg::ialsa_op_t opKind,
  output logic [1:0] addrMode,
  output logic [4:0] dstIdx,
  output logic [4:0] src1Idx,
  output logic [4:0] src2Idx,
  output logic [4:0] src3Idx,
  output logic [31:0] src1Val,
  output logic [31:0] src2Val,
  output logic [31:0] src3Val,
  output logic [15:0] immVal
);
  //////////////////////////////////////////////////////////////////
  // idle values from time zero
  initial begin
    opValid = 1'b0;
    opKind = ialsa_pkg::OP_SUM2;
    addrMode = 2'h0;
    dstIdx = 5'h00;
    src1Idx = 5'h00;
    src2Idx = 5'h00;
    src3Idx = 5'h00;
    src1Val = 32'h00000000;
    src2Val = 32'h00000000;
    src3Val = 32'h00000000;
    immVal = 16'h0000;
  end

  //////////////////////////////////////////////////////////////////
  // one operation, held up to the taking edge only
  task automatic issue(input ialsa_pkg::ialsa_op_t k, input logic [1:0] m, input logic [4:0] d,
                       input logic [4:0] s1, input logic [4:0] s2, input logic [4:0] s3,
                       input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
                       input logic [15:0] imm);
    @(posedge core_clk);
    opValid <= 1'b1;
    opKind <= k;
    addrMode <= m;
    dstIdx <= d;
    src1Idx <= s1;
    src2Idx <= s2;
    src3Idx <= s3;
    src1Val <= a;
    src2Val <= b;
    src3Val <= c; // store value fetched at issue, before any update
    immVal <= imm;
    @(posedge core_clk);
    opValid <= 1'b0;
    // operands go stale: scramble so nothing leans on held values
    src1Val <= ~a;
    src2Val <= ~b;
    src3Val <= ~c;
    immVal <= ~imm;
  endtask
endmodule

// ==== tb/tb_integer_add_logic_shift_alu.sv ====
// self-checking bench for the integer add, logic and shift datapath
`timescale 1ns/1ns
module tb_integer_add_logic_shift_alu;
  // clock, reset, bus master signals
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDat = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  // issue and result nets
  logic opValid;
  ialsa_pkg::ialsa_op_t opKind;
  logic [1:0] addrMode;
  logic [4:0] dstIdx, src1Idx, src2Idx, src3Idx, resIdx;
  logic [31:0] src1Val, src2Val, src3Val, resData, storeData, rd;
  logic [15:0] immVal;
  logic resValid, storeValid, illegalOp;
  logic [6:0] flagsOut;
  // score counters
  int err_count = 0;
  int total_checks = 0;

  always #2 core_clk = ~core_clk;

  //////////////////////////////////////////////////////////////////
  ialsa_issue_model drv (.core_clk(core_clk), .opValid(opValid), .opKind(opKind), .addrMode(addrMode),
    .dstIdx(dstIdx), .src1Idx(src1Idx), .src2Idx(src2Idx), .src3Idx(src3Idx), .src1Val(src1Val),
    .src2Val(src2Val), .src3Val(src3Val), .immVal(immVal));
  ialsa_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(4'hf), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .opValid(opValid), .opKind(opKind), .addrMode(addrMode), .dstIdx(dstIdx),
    .src1Idx(src1Idx), .src2Idx(src2Idx), .src3Idx(src3Idx), .src1Val(src1Val), .src2Val(src2Val),
    .src3Val(src3Val), .immVal(immVal), .resValid(resValid), .resIdx(resIdx), .resData(resData),
    .storeValid(storeValid), .storeData(storeData), .illegalOp(illegalOp), .flagsOut(flagsOut));

  //////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic wishbone cycle; waits for ack, bounded
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    // a slave that never answers ends the run as a failure
    if (wb_ack_o !== 1'b1) begin
      err_count++;
      final_report();
    end
    q = wb_dat_o;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  // legal op: result one cycle after issue, store only for parallel forms
  task automatic op(input ialsa_pkg::ialsa_op_t k, input logic [1:0] m, input logic [4:0] d,
                    input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
                    input logic [15:0] imm, input logic [31:0] er, input logic [6:0] ef);
    logic par;
    par = (k == ialsa_pkg::OP_SUM_STORE) || (k == ialsa_pkg::OP_CONJ_STORE);
    drv.issue(k, m, d, d, 5'h01, d, a, b, c, imm);
    #1;
    check(resValid, 1'b1);
    check(illegalOp, 1'b0);
    check(resIdx, d);
    check(resData, er);
    check(flagsOut, ef);
    check(storeValid, par);
    if (par) check(storeData, c);
  endtask

  // refused op: no result, no store, flags untouched
  task automatic bad(input ialsa_pkg::ialsa_op_t k, input logic [4:0] d, input logic [4:0] s3);
    logic [6:0] f;
    f = flagsOut;
    drv.issue(k, 2'h0, d, 5'h01, 5'h01, s3, 32'h1, 32'h1, 32'h1, 16'h0);
    #1;
    check(illegalOp, 1'b1);
    check(resValid | storeValid, 1'b0);
    check(flagsOut, f);
  endtask

  //////////////////////////////////////////////////////////////////
  // cut a hang short
  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    final_report();
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 16; i += 4) begin
      wb(1'b0, 8'(i), 32'h0, rd);
      check(rd, 32'h0); // registers and unmapped place read zero
    end
    check(flagsOut, 7'h00);
    $display("reset test done");
  endtask

  task automatic t_sum();
    wb(1'b1, ialsa_pkg::ADDR_FLAGS, 32'h50, rd); // preset UF and LATCHED_UNDERFLOW
    op(ialsa_pkg::OP_SUM3, 2'h0, 5'h05, 32'hdc, 32'ha0, 32'h0, 16'h0, 32'h17c, 7'h40);
    op(ialsa_pkg::OP_SUM2, 2'h0, 5'h07, 32'hffffffcb, 32'h35, 32'h0, 16'h0, 32'h0, 7'h45);
    op(ialsa_pkg::OP_SUM3, 2'h0, 5'h02, 32'h7fffffff, 32'h1, 32'h0, 16'h0, 32'h80000000, 7'h6a);
    wb(1'b1, ialsa_pkg::ADDR_CTRL, 32'h1, rd);
    op(ialsa_pkg::OP_SUM3, 2'h0, 5'h1b, 32'h7fffffff, 32'h1, 32'h0, 16'h0, 32'h7fffffff, 7'h62);
    op(ialsa_pkg::OP_SUM2, 2'h3, 5'h02, 32'h80000000, 32'h0, 32'h0, 16'h8000, 32'h80000000, 7'h6b);
    $display("sum test done");
  endtask

  task automatic t_logic();
    op(ialsa_pkg::OP_CONJ2, 2'h0, 5'h02, 32'haff, 32'h80, 32'h0, 16'h0, 32'h80, 7'h61);
    op(ialsa_pkg::OP_CONJ3, 2'h3, 5'h04, 32'h80000000, 32'hffffffff, 32'h0, 16'h0, 32'h80000000, 7'h69);
    op(ialsa_pkg::OP_CLEAR2, 2'h3, 5'h02, 32'hffffffff, 32'h0, 32'h0, 16'h8000, 32'hffff7fff, 7'h69);
    op(ialsa_pkg::OP_CLEAR3, 2'h1, 5'h07, 32'hc2f, 32'ha02, 32'h0, 16'h0, 32'h42d, 7'h61);
    op(ialsa_pkg::OP_CLEAR3, 2'h2, 5'h00, 32'hfff, 32'hfff, 32'h0, 16'h0, 32'h0, 7'h65);
    $display("logic test done");
  endtask

  task automatic t_shift();
    op(ialsa_pkg::OP_SHIFT2, 2'h0, 5'h03, 32'hae000, 32'h110, 32'h0, 16'h0, 32'he0000000, 7'h68);
    op(ialsa_pkg::OP_SHIFT2, 2'h1, 5'h05, 32'haec00001, 32'hffffff68, 32'h0, 16'h0, 32'hffffffae, 7'h69);
    op(ialsa_pkg::OP_SHIFT2, 2'h2, 5'h05, 32'h55, 32'h0, 32'h0, 16'h0, 32'h55, 7'h60);
    op(ialsa_pkg::OP_SHIFT2, 2'h0, 5'h09, 32'h3, 32'h1f, 32'h0, 16'h0, 32'h80000000, 7'h68);
    op(ialsa_pkg::OP_SHIFT2, 2'h0, 5'h02, 32'h1, 32'h20, 32'h0, 16'h0, 32'h0, 7'h65);
    $display("shift test done");
  endtask

  task automatic t_parallel();
    op(ialsa_pkg::OP_SUM_STORE, 2'h0, 5'h05, 32'hdc, 32'h12c, 32'h35, 16'h0, 32'h208, 7'h60);
    op(ialsa_pkg::OP_CONJ_STORE, 2'h0, 5'h07, 32'ha323, 32'h5c53, 32'h35, 16'h0, 32'h3, 7'h60);
    op(ialsa_pkg::OP_SUM_STORE, 2'h0, 5'h00, 32'h7fffffff, 32'h5, 32'h7, 16'h0, 32'h7fffffff, 7'h62);
    $display("parallel test done");
  endtask

  task automatic t_refuse();
    bad(ialsa_pkg::OP_SUM3, 5'h1c, 5'h00);
    bad(ialsa_pkg::OP_CONJ_STORE, 5'h08, 5'h00);
    bad(ialsa_pkg::OP_SUM_STORE, 5'h01, 5'h08);
    wb(1'b1, ialsa_pkg::ADDR_OPCNT, 32'hff, rd); // read-only, write ignored
    wb(1'b0, ialsa_pkg::ADDR_OPCNT, 32'h0, rd);
    check(rd, 32'h12); // eighteen legal operations, refused ones not counted
    wb(1'b0, ialsa_pkg::ADDR_FLAGS, 32'h0, rd);
    check(rd, 32'h62);
    $display("refusal test done");
  endtask

  //////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_sum();
    t_logic();
    t_shift();
    t_parallel();
    t_refuse();
    final_report();
  end
endmodule

// ==== verilog/ialsa_core.sv ====
// integer add, conjunction, clear-bits and shift datapath with wishbone status registers
`timescale 1ns/1ns
module ialsa_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ialsa_pkg::WB_ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // operation issue from the decoder
  input wire logic opValid,
  input wire ialsa_pkg::ialsa_op_t opKind,
  input wire logic [1:0] addrMode,
  input wire logic [ialsa_pkg::IDX_W-1:0] dstIdx,
  input wire logic [ialsa_pkg::IDX_W-1:0] src1Idx,
  input wire logic [ialsa_pkg::IDX_W-1:0] src2Idx,
  input wire logic [ialsa_pkg::IDX_W-1:0] src3Idx,
  input wire logic [ialsa_pkg::DATA_W-1:0] src1Val,
  input wire logic [ialsa_pkg::DATA_W-1:0] src2Val,
  input wire logic [ialsa_pkg::DATA_W-1:0] src3Val,
  input wire logic [ialsa_pkg::IMM_W-1:0] immVal,
  // result toward the register file
  output logic resValid,
  output logic [ialsa_pkg::IDX_W-1:0] resIdx,
  output logic [ialsa_pkg::DATA_W-1:0] resData,
  // parallel store toward data memory
  output logic storeValid,
  output logic [ialsa_pkg::DATA_W-1:0] storeData,
  // status
  output logic illegalOp,
  output logic [ialsa_pkg::FLAG_W-1:0] flagsOut
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // true when the three-operand field marks src1 as a register
  function automatic logic triSrc1IsReg(input logic [1:0] mode);
    triSrc1IsReg = ~mode[ialsa_pkg::TRI_SRC1_IND_BIT];
  endfunction

  // true when the three-operand field marks src2 as a register
  function automatic logic triSrc2IsReg(input logic [1:0] mode);
    triSrc2IsReg = ~mode[ialsa_pkg::TRI_SRC2_IND_BIT];
  endfunction

  // register index check against a limit, only when a register is used
  function automatic logic idxOk(input logic used, input logic [4:0] idx, input logic [4:0] last);
    idxOk = !used || (idx <= last);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  // saturate_mode control bit, written by software
  logic satMode_reg;
  // flags: latched_underflow, latched_overflow, underflow_flag, N, Z, V, C
  logic [ialsa_pkg::FLAG_W-1:0] flags_reg;
  logic [ialsa_pkg::FLAG_W-1:0] flags_next;
  // count of operations taken, for software visibility
  logic [31:0] opCount_reg;
  // registered outputs
  logic resValid_reg;
  logic [ialsa_pkg::IDX_W-1:0] resIdx_reg;
  logic [ialsa_pkg::DATA_W-1:0] resData_reg;
  logic storeValid_reg;
  logic [ialsa_pkg::DATA_W-1:0] storeData_reg;
  logic illegalOp_reg;
  logic wbAck_reg;
  logic [31:0] wbDat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // operand selection

  // kind classes
  wire isSum = (opKind == ialsa_pkg::OP_SUM2) || (opKind == ialsa_pkg::OP_SUM3) ||
               (opKind == ialsa_pkg::OP_SUM_STORE);
  wire isShift = (opKind == ialsa_pkg::OP_SHIFT2);
  wire isLogic = !isSum && !isShift;
  wire isParallel = (opKind == ialsa_pkg::OP_SUM_STORE) || (opKind == ialsa_pkg::OP_CONJ_STORE);
  wire isTwoOp = (opKind == ialsa_pkg::OP_SUM2) || (opKind == ialsa_pkg::OP_CONJ2) ||
                 (opKind == ialsa_pkg::OP_CLEAR2) || isShift;
  wire isClear = (opKind == ialsa_pkg::OP_CLEAR2) || (opKind == ialsa_pkg::OP_CLEAR3);

  // immediate only exists in the general field, code 11
  wire useImm = isTwoOp && (addrMode == ialsa_pkg::GEN_IMM);
  // logical ops take the immediate unsigned, arithmetic ones signed
  wire [31:0] immZero = {16'h0000, immVal};
  wire [31:0] immSign = {{16{immVal[15]}}, immVal};
  wire [31:0] immExt = isLogic ? immZero : immSign;
  // second operand: immediate, or the fetched value for register, direct, indirect
  wire [31:0] opB = useImm ? immExt : src2Val;
  // first operand: for two-operand forms this is the destination register read
  wire [31:0] opA = src1Val;

  ////////////////////////////////////////////////////////////////////////////
  // legality of register numbers

  // register source flags per form
  wire src1Reg = isTwoOp ? 1'b1 : (isParallel ? 1'b1 : triSrc1IsReg(addrMode));
  wire src2Reg = isTwoOp ? (addrMode == ialsa_pkg::GEN_REG) : (!isParallel && triSrc2IsReg(addrMode));
  // parallel forms: dst1, src1 and src3 must be 0-7; src2 always indirect
  wire parOk = idxOk(1'b1, dstIdx, ialsa_pkg::PAR_REG_LAST) && idxOk(1'b1, src1Idx, ialsa_pkg::PAR_REG_LAST) &&
               idxOk(1'b1, src3Idx, ialsa_pkg::PAR_REG_LAST);
  // other forms: every register use within 0-27
  wire wideOk = idxOk(1'b1, dstIdx, ialsa_pkg::REG_LAST) && idxOk(src1Reg, src1Idx, ialsa_pkg::REG_LAST) &&
                idxOk(src2Reg, src2Idx, ialsa_pkg::REG_LAST);
  wire opLegal = isParallel ? parOk : wideOk;
  wire opTake = opValid && opLegal;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic

  // unsigned carry and signed overflow from one adder
  wire [32:0] sumWide = {1'b0, opA} + {1'b0, opB};
  wire sumCarry = sumWide[32];
  wire sumOvf = (opA[31] == opB[31]) && (sumWide[31] != opA[31]);
  // saturation only when the mode bit is set
  wire [31:0] sumSat = opA[31] ? ialsa_pkg::INT_MIN : ialsa_pkg::INT_MAX;
  wire [31:0] sumRes = (satMode_reg && sumOvf) ? sumSat : sumWide[31:0];

  // conjunction and clear-bits share one gate row, second operand inverted for clear
  wire [31:0] logicB = isClear ? ~opB : opB;
  wire [31:0] logicRes = opA & logicB;

  // shifter: count is the low seven bits of the count operand
  wire [31:0] shiftRes;
  wire shiftCarry;
  ialsa_shifter #(
    .DATA_W(ialsa_pkg::DATA_W),
    .CNT_W(ialsa_pkg::SHIFT_CNT_W)
  ) u_shifter (
    .operand(opA),
    .count(opB[ialsa_pkg::SHIFT_CNT_W-1:0]),
    .shifted(shiftRes),
    .carryOut(shiftCarry)
  );

  // final result
  wire [31:0] opRes = isSum ? sumRes : (isShift ? shiftRes : logicRes);
  // carry of a shift only lands when the destination is one of registers 0-7
  wire shiftCarryLands = (dstIdx <= ialsa_pkg::PAR_REG_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode

  wire wbReq = wb_cyc_i && wb_stb_i && !wbAck_reg;
  // writes land on the edge where the master sees ack, the same edge it releases the request
  wire wbWr = wb_cyc_i && wb_stb_i && wbAck_reg && wb_we_i && wb_sel_i[0];
  wire hitCtrl = (wb_adr_i == ialsa_pkg::ADDR_CTRL);
  wire hitFlags = (wb_adr_i == ialsa_pkg::ADDR_FLAGS);
  wire hitCount = (wb_adr_i == ialsa_pkg::ADDR_OPCNT);
  // read mux; unmapped addresses read zero and are still acknowledged
  wire [31:0] rdMux = hitCtrl ? {31'h0, satMode_reg} :
                      hitFlags ? {25'h0, flags_reg} :
                      hitCount ? opCount_reg : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // flag update

  // an operation's update wins over a software write in the same cycle,
  // so a latched overflow is never lost to a concurrent clear
  always_comb begin
    flags_next = flags_reg;
    if (opTake) begin
      flags_next[ialsa_pkg::FLG_N] = opRes[31];
      flags_next[ialsa_pkg::FLG_Z] = (opRes == 32'h00000000);
      flags_next[ialsa_pkg::FLG_UF] = 1'b0;
      if (isSum) begin
        flags_next[ialsa_pkg::FLG_V] = sumOvf;
        flags_next[ialsa_pkg::FLG_C] = sumCarry;
        flags_next[ialsa_pkg::FLG_LV] = flags_reg[ialsa_pkg::FLG_LV] | sumOvf;
      end else if (isShift) begin
        // overflow of the shift is not tracked here; V reads low
        flags_next[ialsa_pkg::FLG_V] = 1'b0;
        if (shiftCarryLands) begin
          flags_next[ialsa_pkg::FLG_C] = shiftCarry;
        end
      end else begin
        // logical: carry and latched bits untouched
        flags_next[ialsa_pkg::FLG_V] = 1'b0;
      end
    end else if (wbWr && hitFlags) begin
      flags_next = wb_dat_i[ialsa_pkg::FLAG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // control and flags
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      satMode_reg <= ialsa_pkg::CTRL_SAT_RESET;
      flags_reg <= ialsa_pkg::FLAGS_RESET;
      opCount_reg <= 32'h00000000;
    end else begin
      if (wbWr && hitCtrl) begin
        satMode_reg <= wb_dat_i[ialsa_pkg::CTRL_SAT_BIT];
      end
      flags_reg <= flags_next;
      if (opTake) begin
        opCount_reg <= opCount_reg + 32'h00000001;
      end
    end
  end

  // result and store, one cycle after issue
  // all operands are sampled at the issue edge, so the store carries the
  // pre-update register value and src2 is read before the store lands
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      resValid_reg <= 1'b0;
      resIdx_reg <= '0;
      resData_reg <= 32'h00000000;
      storeValid_reg <= 1'b0;
      storeData_reg <= 32'h00000000;
      illegalOp_reg <= 1'b0;
    end else begin
      resValid_reg <= opTake;
      resIdx_reg <= dstIdx;
      resData_reg <= opRes;
      storeValid_reg <= opTake && isParallel;
      storeData_reg <= src3Val;
      illegalOp_reg <= opValid && !opLegal;
    end
  end

  // wishbone ack and read data; ack one cycle after the request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wbAck_reg <= 1'b0;
      wbDat_reg <= 32'h00000000;
    end else begin
      wbAck_reg <= wbReq;
      wbDat_reg <= wbReq ? rdMux : 32'h00000000;
    end
  end

  // outputs straight from flip-flops
  assign resValid = resValid_reg;
  assign resIdx = resIdx_reg;
  assign resData = resData_reg;
  assign storeValid = storeValid_reg;
  assign storeData = storeData_reg;
  assign illegalOp = illegalOp_reg;
  assign flagsOut = flags_reg;
  assign wb_ack_o = wbAck_reg;
  assign wb_dat_o = wbDat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // issue followed by completion
  sequence issueLegal;
    opValid && opLegal;
  endsequence

  chk_one_cycle_done: assert property (opValid |=> (resValid ^ illegalOp))
    else $error("operation did not complete in one cycle");

  chk_store_old_value: assert property ((issueLegal and isParallel) |=>
                                        storeValid && resValid && storeData == $past(src3Val))
    else $error("parallel store missing or wrong value");

  // a store pulse from a non-parallel form would write memory behind the decoder's back
  chk_store_only_par: assert property ((issueLegal and !isParallel) |=> !storeValid)
    else $error("store issued by a non-parallel form");

  chk_parallel_limits: assert property ((opValid && isParallel && dstIdx > 5'h07) |=>
                                        illegalOp && !storeValid && !resValid)
    else $error("parallel form accepted a high register");

  chk_conj_result: assert property ((issueLegal and opKind == ialsa_pkg::OP_CONJ3) |=>
                                    resData == ($past(src1Val) & $past(src2Val)))
    else $error("conjunction result wrong");

  chk_clear_result: assert property ((issueLegal and opKind == ialsa_pkg::OP_CLEAR3) |=>
                                     resData == ($past(src1Val) & ~$past(src2Val)))
    else $error("clear-bits result wrong");

  chk_clear_imm_zext: assert property ((issueLegal and opKind == ialsa_pkg::OP_CLEAR2 and useImm) |=>
                                       resData == ($past(src1Val) & ~{16'h0000, $past(immVal)}))
    else $error("clear-bits immediate not zero-extended");

  chk_sum_saturate: assert property ((issueLegal and isSum and satMode_reg and sumOvf) |=>
                                     resData == ($past(src1Val[31]) ? ialsa_pkg::INT_MIN : ialsa_pkg::INT_MAX))
    else $error("overflowing sum not clamped");

  chk_logic_flags: assert property ((issueLegal and isLogic) |=>
                                    !flagsOut[ialsa_pkg::FLG_V] && !flagsOut[ialsa_pkg::FLG_UF] &&
                                    $stable(flagsOut[ialsa_pkg::FLG_C]) &&
                                    $stable(flagsOut[ialsa_pkg::FLG_LV]) && $stable(flagsOut[ialsa_pkg::FLG_LUF]))
    else $error("logical op disturbed protected flags");

  // N and Z follow the value written back, saturated or not
  chk_sum_flags: assert property ((issueLegal and isSum) |=>
                                  !flagsOut[ialsa_pkg::FLG_UF] && (flagsOut[ialsa_pkg::FLG_N] == resData[31]) &&
                                  (flagsOut[ialsa_pkg::FLG_Z] == (resData == 32'h00000000)))
    else $error("sum status flags wrong");

  chk_sum_latch_ovf: assert property ((issueLegal and isSum and sumOvf) |=>
                                      flagsOut[ialsa_pkg::FLG_LV] && flagsOut[ialsa_pkg::FLG_V] &&
                                      $stable(flagsOut[ialsa_pkg::FLG_LUF]))
    else $error("sum overflow not latched");

  chk_zero_shift: assert property ((issueLegal and isShift and opB[6:0] == 7'h00 and shiftCarryLands)
                                   |=> resData == $past(src1Val) && !flagsOut[ialsa_pkg::FLG_C])
    else $error("zero shift altered value or carry");

  // a destination above register 7 keeps its carry whatever the count
  chk_shift_carry_kept: assert property ((issueLegal and isShift and !shiftCarryLands) |=>
                                         $stable(flagsOut[ialsa_pkg::FLG_C]))
    else $error("shift carry landed on a high destination");

endmodule

// ==== verilog/ialsa_pkg.sv ====
// shared constants and types for the integer add, logic and shift datapath
package ialsa_pkg;

  // datapath widths
  localparam int DATA_W = 32;
  localparam int IDX_W = 5;
  localparam int IMM_W = 16;
  localparam int SHIFT_CNT_W = 7;
  localparam int FLAG_W = 7;
  localparam int WB_ADDR_W = 8;

  // register index limits
  localparam logic [4:0] REG_LAST = 5'h1b;
  localparam logic [4:0] PAR_REG_LAST = 5'h07;

  // general addressing field codes
  localparam logic [1:0] GEN_REG = 2'h0;
  localparam logic [1:0] GEN_DIRECT = 2'h1;
  localparam logic [1:0] GEN_INDIRECT = 2'h2;
  localparam logic [1:0] GEN_IMM = 2'h3;

  // three-operand field: bit 0 marks src1 indirect, bit 1 marks src2 indirect
  localparam int TRI_SRC1_IND_BIT = 0;
  localparam int TRI_SRC2_IND_BIT = 1;

  // status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_UF = 4;
  localparam int FLG_LV = 5;
  localparam int FLG_LUF = 6;
  localparam logic [6:0] FLAGS_RESET = 7'h00;

  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_OPCNT = 8'h08;
  localparam int CTRL_SAT_BIT = 0;
  localparam logic CTRL_SAT_RESET = 1'h0;

  // saturation limits
  localparam logic [31:0] INT_MAX = 32'h7fffffff;
  localparam logic [31:0] INT_MIN = 32'h80000000;

  // operation kinds offered by the decoder
  typedef enum logic [3:0] {
    OP_SUM2,
    OP_SUM3,
    OP_CONJ2,
    OP_CONJ3,
    OP_CLEAR2,
    OP_CLEAR3,
    OP_SHIFT2,
    OP_SUM_STORE,
    OP_CONJ_STORE
  } ialsa_op_t;

endpackage

// ==== verilog/ialsa_shifter.sv ====
// arithmetic shifter with carry-out, count taken as a signed seven-bit value
`timescale 1ns/1ns
module ialsa_shifter #(
  parameter int DATA_W = 32,
  parameter int CNT_W = 7
) (
  // operand and count
  input wire logic [DATA_W-1:0] operand,
  input wire logic [CNT_W-1:0] count,
  // shifted value and last bit out
  output logic [DATA_W-1:0] shifted,
  output logic carryOut
);

  // left path: zero fill, last bit out lands just above the word
  logic [2*DATA_W-1:0] leftWide;
  // right path: sign fill, last bit out lands just below the word
  logic signed [2*DATA_W:0] rightWide;
  // magnitude of a negative count
  logic [CNT_W-1:0] rightMag;

  assign rightMag = ~count + 1'b1;
  assign leftWide = {{DATA_W{1'b0}}, operand} << count;
  assign rightWide = $signed({{DATA_W{operand[DATA_W-1]}}, operand, 1'b0}) >>> rightMag;

  // pick direction from the count sign
  always_comb begin
    if (count == '0) begin
      // no shift, carry forced low
      shifted = operand;
      carryOut = 1'b0;
    end else if (count[CNT_W-1] == 1'b0) begin
      // counts beyond the word width simply clear it
      shifted = leftWide[DATA_W-1:0];
      carryOut = leftWide[DATA_W];
    end else begin
      shifted = rightWide[DATA_W:1];
      carryOut = rightWide[0];
    end
  end

endmodule
